// [include/dp_pkg.sv]
// constants, codes and field layouts for the execution datapath
// assumes one cpu clock and microcode field decoders driving the code ports
`default_nettype none
package dp_pkg;

   // word and field widths
   localparam int unsigned DATA_W = 16;            // every bus and buffer
   localparam int unsigned DISPATCHER_FLAG_W = 8;             // displacement field of the instruction
   localparam int unsigned DIGIT_W = 4;            // one decimal digit
   localparam int unsigned DIGITS = DATA_W / DIGIT_W;

   // reset values
   localparam logic [15:0] BUF_RESET = 16'h0000;   // operand and output buffers
   localparam logic [15:0] CAUSE_RESET = 16'h0000; // both cause words
   localparam logic OVF_RESET = 1'b0;              // overflow flip-flop

   // decimal corrector constants
   localparam logic [3:0] DEC_SIX = 4'h6;          // correction added to a digit
   localparam logic [3:0] DEC_MAX = 4'h9;          // largest legal digit

   // status word layout
   localparam int unsigned STATUS_OVF_BIT = 4;     // overflow bit of the status word

   // run-mode cause word: bit 10 is constant zero; 11, 12, 15 follow live levels
   localparam int unsigned RUN_ZERO_BIT = 10;
   localparam logic [15:0] RUN_ZERO_MASK = 16'h0400;
   localparam logic [15:0] RUN_LEVEL_MASK = 16'h9800;
   // halt-mode cause word: bits 11 and 12 constant zero; 13, 14, 15 live levels
   localparam logic [15:0] HALT_ZERO_MASK = 16'h1800;
   localparam logic [15:0] HALT_LEVEL_MASK = 16'he000;

   // alu function field; bit 3 low selects the arithmetic group
   typedef enum logic [3:0]
   {
      FN_NOP     = 4'h0,   // pass left operand
      FN_ADD     = 4'h1,
      FN_SUB     = 4'h2,
      FN_INC     = 4'h3,
      FN_DEC_ADD = 4'h4,   // decimal add through the corrector
      FN_AND     = 4'h8,
      FN_OR      = 4'h9,
      FN_XOR     = 4'ha,
      FN_PASS_R  = 4'hb,
      FN_LSHIFT  = 4'hc,   // left_shift_function_code
      FN_RSHIFT  = 4'hd    // right_shift_function_code
   } alu_func_t;

   // shift field decoder output
   typedef enum logic [2:0]
   {
      SH_NONE  = 3'h0,
      SH_LEFT  = 3'h1,
      SH_RIGHT = 3'h2,
      SH_SWAP  = 3'h3,
      SH_ROTL  = 3'h4,
      SH_ROTR  = 3'h5
   } shift_t;

   // special field codes that touch this block
   typedef enum logic [1:0]
   {
      SP_NONE    = 2'h0,
      SP_SET_OVF = 2'h1,
      SP_CLR_OVF = 2'h2,
      SP_CLR_INT = 2'h3    // clear_interrupt_flags_code
   } special_t;

   // base register choice for the address sum
   typedef enum logic [1:0]
   {
      BASE_PROGRAM = 2'h0,
      BASE_DATA    = 2'h1,
      BASE_MARKER  = 2'h2,
      BASE_LIMIT   = 2'h3
   } base_sel_t;

   // right-bus source codes for the cause words
   typedef enum logic [1:0]
   {
      SRC_NONE  = 2'h0,
      SRC_RUN   = 2'h1,
      SRC_HALT  = 2'h2
   } src_t;

endpackage
`default_nettype wire

// [rtl/decimal_corrector.sv]
// decimal corrector: digit-wise add with plus-six correction and digit checks
// assumes both operands are packed decimal, four digits of four bits
`timescale 1ns/1ns
`default_nettype none
module decimal_corrector
(
   // operands from the buffers
   input  wire logic [15:0] left_i,
   input  wire logic [15:0] right_i,
   // corrected sum and flags
   output logic      [15:0] sum_o,
   output logic             carry_o,
   output logic             invalid_o
);
   import dp_pkg::*;

   logic [DIGITS:0]  carry;     // carry chain between digits
   logic [DIGITS-1:0] bad;      // digit out of range per position

   assign carry[0] = 1'b0;

   // one adder and corrector per digit
   genvar d;
   generate
      for (d = 0; d < DIGITS; d++)
      begin : g_digit
         logic [4:0] raw;       // binary digit sum
         logic [4:0] fixed;     // sum after correction
         always_comb
         begin
            raw = 5'({1'b0, left_i[d*4 +: 4]}) + 5'({1'b0, right_i[d*4 +: 4]})
                  + 5'(carry[d]);
            // add six when the digit sum passes nine
            if (raw > 5'({1'b0, DEC_MAX}))
               fixed = raw + 5'({1'b0, DEC_SIX});
            else
               fixed = raw;
         end
         assign sum_o[d*4 +: 4] = fixed[3:0];
         assign carry[d+1] = (raw > 5'({1'b0, DEC_MAX}));
         assign bad[d] = (left_i[d*4 +: 4] > DEC_MAX) || (right_i[d*4 +: 4] > DEC_MAX);
      end
   endgenerate

   assign carry_o = carry[DIGITS];
   assign invalid_o = |bad;

endmodule
`default_nettype wire

// [rtl/exec_datapath.sv]
// execution datapath: pre-adder, address sum, operand buffers, alu, shifter,
// decimal corrector, memory output buffers, overflow flag, two cause words
// assumes microcode decoders drive the code ports on the cpu clock;
// cause event inputs arrive from other domains and are synchronised here
//
// Behaviour
// - pre-add displacement to index for indexed access
// - absolute address: pre-sum plus chosen base, one cycle
// - left buffer loads left bus, shifts left
// - right buffer loads right bus, shifts right
// - alu arithmetic or logic group, 16-bit result
// - shifter: left, right, swap, rotate onto result
// - decimal add: plus six per digit, carries
// - invalid decimal digit sets overflow
// - address output buffer holds result bus address
// - data output buffer holds result bus data
// - run cause word readable, cleared by code
// - run cause bit layout, bit 10 zero
// - halt cause word readable, cleared by code
// - halt cause bit layout
// - overflow flip-flop: capture, set, clear, status bit
`timescale 1ns/1ns
`default_nettype none
module exec_datapath
(
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              reset_i,
   // address computation
   input  wire logic [15:0]       current_instruction_word_i,
   input  wire logic [15:0]       index_reg_i,
   input  wire logic [15:0]       program_base_reg_i,
   input  wire logic [15:0]       data_base_reg_i,
   input  wire logic [15:0]       stack_marker_reg_i,
   input  wire logic [15:0]       stack_limit_reg_i,
   input  wire dp_pkg::base_sel_t base_sel_i,
   input  wire logic              addr_calc_i,
   // operand buses and buffer controls
   input  wire logic [15:0]       left_bus_i,
   input  wire logic              left_load_i,
   input  wire logic [15:0]       right_bus_i,
   input  wire logic              right_load_i,
   // microinstruction fields
   input  wire dp_pkg::alu_func_t func_i,
   input  wire dp_pkg::shift_t    shift_i,
   input  wire dp_pkg::special_t  special_i,
   input  wire dp_pkg::src_t      src_i,
   input  wire logic              flag_capture_enable_i,
   input  wire logic              addr_buf_load_i,
   input  wire logic              data_buf_load_i,
   // asynchronous cause sources
   input  wire logic [15:0]       run_events_i,
   input  wire logic [15:0]       halt_events_i,
   // results
   output logic [15:0]            effective_address_o,
   output logic [15:0]            result_bus_o,
   output logic [15:0]            right_read_o,
   output logic [15:0]            status_word_o,
   output logic [15:0]            address_output_buffer_o,
   output logic [15:0]            data_output_buffer_o,
   output logic [15:0]            run_interrupt_cause_o,
   output logic [15:0]            halt_interrupt_cause_o
);
   import dp_pkg::*;

   // registered state
   logic [15:0] left_buf, right_buf;          // operand buffers
   logic [15:0] address_output_buffer;        // toward memory_control_bus
   logic [15:0] data_output_buffer;           // toward memory_control_bus
   logic [15:0] eff_addr, result_q, read_q;   // output copies
   logic        overflow_flipflop;            // status overflow
   logic [15:0] run_interrupt_cause;          // run-mode causes
   logic [15:0] halt_interrupt_cause;         // halt-mode causes
   logic [15:0] run_meta, run_sync;           // run event synchroniser
   logic [15:0] halt_meta, halt_sync;         // halt event synchroniser

   // next values
   logic [15:0] next_left, next_right, next_addr_buf, next_data_buf;
   logic [15:0] next_eff_addr, next_read, next_run, next_halt;
   logic        next_ovf;

   // combinational datapath
   logic [15:0] pre_sum;        // pre-adder output
   logic [15:0] base_val;       // chosen base register
   logic [15:0] alu_out;        // intermediate result bus
   logic        alu_ovf;        // alu overflow
   logic [15:0] shift_out;      // result bus
   logic [15:0] dec_sum;
   logic        dec_invalid;

   // decimal add of the two buffers
   decimal_corrector u_dec
   (
      .left_i    (left_buf),
      .right_i   (right_buf),
      .sum_o     (dec_sum),
      .carry_o   (),
      .invalid_o (dec_invalid)
   );

   // address pre-add and base sum
   always_comb
   begin
      pre_sum = index_reg_i + 16'(current_instruction_word_i[DISPATCHER_FLAG_W-1:0]);
      case (base_sel_i)
         BASE_PROGRAM: base_val = program_base_reg_i;
         BASE_DATA:    base_val = data_base_reg_i;
         BASE_MARKER:  base_val = stack_marker_reg_i;
         default:      base_val = stack_limit_reg_i;
      endcase
      if (addr_calc_i)
         next_eff_addr = pre_sum + base_val;
      else
         next_eff_addr = eff_addr;
   end

   // alu and shifter
   always_comb
   begin
      alu_ovf = 1'b0;
      case (func_i)
         FN_ADD:
         begin
            alu_out = left_buf + right_buf;
            alu_ovf = (left_buf[15] == right_buf[15]) && (alu_out[15] != left_buf[15]);
         end
         FN_SUB:
         begin
            alu_out = left_buf - right_buf;
            alu_ovf = (left_buf[15] != right_buf[15]) && (alu_out[15] != left_buf[15]);
         end
         FN_INC:
         begin
            alu_out = left_buf + 16'h0001;
            alu_ovf = (left_buf == 16'h7fff);
         end
         FN_DEC_ADD:
         begin
            alu_out = dec_sum;
            alu_ovf = dec_invalid;
         end
         FN_AND:    alu_out = left_buf & right_buf;
         FN_OR:     alu_out = left_buf | right_buf;
         FN_XOR:    alu_out = left_buf ^ right_buf;
         FN_PASS_R: alu_out = right_buf;
         default:   alu_out = left_buf;
      endcase
      // shift field on the alu result
      case (shift_i)
         SH_LEFT:  shift_out = {alu_out[14:0], 1'b0};
         SH_RIGHT: shift_out = {1'b0, alu_out[15:1]};
         SH_SWAP:  shift_out = {alu_out[7:0], alu_out[15:8]};
         SH_ROTL:  shift_out = {alu_out[14:0], alu_out[15]};
         SH_ROTR:  shift_out = {alu_out[0], alu_out[15:1]};
         default:  shift_out = alu_out;
      endcase
   end

   // buffers, overflow and cause words
   always_comb
   begin
      if (left_load_i)
         next_left = left_bus_i;
      else if (func_i == FN_LSHIFT)
         next_left = {left_buf[14:0], 1'b0};
      else
         next_left = left_buf;
      if (right_load_i)
         next_right = right_bus_i;
      else if (func_i == FN_RSHIFT)
         next_right = {1'b0, right_buf[15:1]};
      else
         next_right = right_buf;
      next_addr_buf = addr_buf_load_i ? shift_out : address_output_buffer;
      next_data_buf = data_buf_load_i ? shift_out : data_output_buffer;
      // set beats clear, captured overflow beats clear
      if (special_i == SP_SET_OVF || (flag_capture_enable_i && alu_ovf))
         next_ovf = 1'b1;
      else if (special_i == SP_CLR_OVF || flag_capture_enable_i)
         next_ovf = 1'b0;
      else
         next_ovf = overflow_flipflop;
      // sticky events, clear code, new events win
      next_run = (special_i == SP_CLR_INT) ? 16'h0000 : run_interrupt_cause;
      next_run = (next_run | run_sync) & ~RUN_LEVEL_MASK;
      // live level bits, bit 10 forced low
      next_run = (next_run | (run_sync & RUN_LEVEL_MASK)) & ~RUN_ZERO_MASK;
      next_halt = (special_i == SP_CLR_INT) ? 16'h0000 : halt_interrupt_cause;
      next_halt = (next_halt | halt_sync) & ~HALT_LEVEL_MASK;
      // live levels, bits 11 and 12 low
      next_halt = (next_halt | (halt_sync & HALT_LEVEL_MASK)) & ~HALT_ZERO_MASK;
      // selected cause word onto the right bus read port
      if (src_i == SRC_RUN)
         next_read = run_interrupt_cause;
      else if (src_i == SRC_HALT)
         next_read = halt_interrupt_cause;
      else
         next_read = 16'h0000;
   end

   // all state on the cpu clock edge
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         left_buf <= BUF_RESET;
         right_buf <= BUF_RESET;
         address_output_buffer <= BUF_RESET;
         data_output_buffer <= BUF_RESET;
         eff_addr <= BUF_RESET;
         result_q <= BUF_RESET;
         read_q <= BUF_RESET;
         overflow_flipflop <= OVF_RESET;
         run_interrupt_cause <= CAUSE_RESET;
         halt_interrupt_cause <= CAUSE_RESET;
         run_meta <= CAUSE_RESET;
         run_sync <= CAUSE_RESET;
         halt_meta <= CAUSE_RESET;
         halt_sync <= CAUSE_RESET;
      end
      else
      begin
         left_buf <= next_left;
         right_buf <= next_right;
         address_output_buffer <= next_addr_buf;
         data_output_buffer <= next_data_buf;
         eff_addr <= next_eff_addr;
         result_q <= shift_out;
         read_q <= next_read;
         overflow_flipflop <= next_ovf;
         run_interrupt_cause <= next_run;
         halt_interrupt_cause <= next_halt;
         run_meta <= run_events_i;
         run_sync <= run_meta;
         halt_meta <= halt_events_i;
         halt_sync <= halt_meta;
      end
   end

   // outputs straight from flip-flops
   assign effective_address_o = eff_addr;
   assign result_bus_o = result_q;
   assign right_read_o = read_q;
   assign status_word_o = 16'({overflow_flipflop, 4'h0});
   assign address_output_buffer_o = address_output_buffer;
   assign data_output_buffer_o = data_output_buffer;
   assign run_interrupt_cause_o = run_interrupt_cause;
   assign halt_interrupt_cause_o = halt_interrupt_cause;

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   addr_sum_a: assert property
      (addr_calc_i |=> effective_address_o == 16'($past(pre_sum) + $past(base_val)))
      else $error("address sum wrong");
   pre_add_a: assert property
      (addr_calc_i && base_sel_i == BASE_DATA |=> effective_address_o ==
       16'($past(index_reg_i) + $past(current_instruction_word_i[7:0]) + $past(data_base_reg_i)))
      else $error("pre-adder wrong");
   left_shift_a: assert property
      (func_i == FN_LSHIFT && !left_load_i |=> left_buf == {$past(left_buf[14:0]), 1'b0})
      else $error("left buffer did not shift");
   right_shift_a: assert property
      (func_i == FN_RSHIFT && !right_load_i |=> right_buf == {1'b0, $past(right_buf[15:1])})
      else $error("right buffer did not shift");
   alu_add_a: assert property
      (func_i == FN_ADD && shift_i == SH_NONE |=>
       result_bus_o == 16'($past(left_buf) + $past(right_buf)))
      else $error("alu add wrong");
   byte_swap_a: assert property
      (func_i == FN_PASS_R && shift_i == SH_SWAP |=>
       result_bus_o == {$past(right_buf[7:0]), $past(right_buf[15:8])})
      else $error("byte swap wrong");
   dec_fix_a: assert property
      (func_i == FN_DEC_ADD && shift_i == SH_NONE && left_buf == 16'h1999
       && right_buf == 16'h0001 |=> result_bus_o == 16'h2000)
      else $error("decimal correction wrong");
   dec_bad_a: assert property
      (func_i == FN_DEC_ADD && flag_capture_enable_i && special_i != SP_CLR_OVF
       && (left_buf[3:0] > DEC_MAX || left_buf[7:4] > DEC_MAX
           || left_buf[11:8] > DEC_MAX || left_buf[15:12] > DEC_MAX)
       |=> status_word_o[STATUS_OVF_BIT])
      else $error("invalid digit missed");
   addr_buf_a: assert property
      (addr_buf_load_i |=> address_output_buffer_o == $past(shift_out)
       ##1 ($past(addr_buf_load_i) || $stable(address_output_buffer_o)))
      else $error("address buffer wrong");
   data_buf_a: assert property
      (data_buf_load_i |=> data_output_buffer_o == $past(shift_out))
      else $error("data buffer wrong");
   run_read_a: assert property
      (src_i == SRC_RUN |=> right_read_o == $past(run_interrupt_cause))
      else $error("run cause read wrong");
   run_clear_a: assert property
      (special_i == SP_CLR_INT && run_sync == 16'h0000 |=> run_interrupt_cause == 16'h0000)
      else $error("run cause not cleared");
   run_zero_a: assert property
      (!run_interrupt_cause[RUN_ZERO_BIT])
      else $error("run bit 10 not zero");
   run_event_a: assert property
      ($rose(run_events_i[0]) |-> ##3 run_interrupt_cause[0])
      else $error("run event lost");
   halt_read_a: assert property
      (src_i == SRC_HALT |=> right_read_o == $past(halt_interrupt_cause))
      else $error("halt cause read wrong");
   halt_event_a: assert property
      ($rose(halt_events_i[2]) |-> ##3 halt_interrupt_cause[2])
      else $error("halt event lost");
   halt_zero_a: assert property
      ((halt_interrupt_cause & HALT_ZERO_MASK) == 16'h0000)
      else $error("halt bits 11 12 not zero");
   ovf_set_a: assert property
      (special_i == SP_SET_OVF |=> status_word_o == 16'h0010)
      else $error("overflow not set");
   ovf_clr_a: assert property
      (special_i == SP_CLR_OVF && !flag_capture_enable_i |=> !overflow_flipflop)
      else $error("overflow not cleared");
   hold_a: assert property
      (!left_load_i && func_i != FN_LSHIFT |=> $stable(left_buf))
      else $error("left buffer changed unasked");

   dec_add_c: cover property (func_i == FN_DEC_ADD && dec_invalid ##1 overflow_flipflop);
   clear_c: cover property (run_interrupt_cause != 16'h0000 ##1 special_i == SP_CLR_INT);
   swap_c: cover property (shift_i == SH_SWAP && addr_buf_load_i);
   addr_c: cover property (addr_calc_i && base_sel_i == BASE_LIMIT);

endmodule
`default_nettype wire

// [tb/mem_ctl_model.sv]
// memory control unit stand-in on the far side of the output buffers
// assumes the bench raises req_i for one cycle when microcode starts a transfer
`timescale 1ns/1ns
`default_nettype none
module mem_ctl_model
(
   // clock
   input  wire logic        ref_clk_i,
   // transfer request and buffer contents on the control bus
   input  wire logic        req_i,
   input  wire logic [15:0] address_i,
   input  wire logic [15:0] data_i,
   // what the memory side took on the last request
   output logic      [15:0] taken_address_o,
   output logic      [15:0] taken_data_o
);
   // take address and data together at a requested edge
   always_ff @(posedge ref_clk_i)
   begin
      if (req_i)
      begin
         taken_address_o <= address_i;
         taken_data_o    <= data_i;
      end
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the execution datapath with a memory-side model
// assumes inputs change at the falling edge and outputs settle by then
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import dp_pkg::*;
   logic ref_clk_i = 1'b0, reset_i = 1'b1, addr_calc, lload, rload, flag_en;
   logic abuf_ld, dbuf_ld, mem_req;
   logic [15:0] current_instruction_word, idx, pb, db, sm, sl, lbus, rbus, run_ev, halt_ev;
   logic [15:0] ea, res, rread, stat, abuf, dbuf, runw, haltw, m_addr, m_data;
   base_sel_t   bsel;
   alu_func_t   func;
   shift_t      shift;
   special_t    spec;
   src_t        src;
   int          err_total = 0, comparisons = 0;
   logic [15:0] sh_exp [6] = '{16'h8c31, 16'h1862, 16'h4618, 16'h318c, 16'h1863, 16'hc618};
   // free-running cpu clock, 10 ns period
   initial forever #5 ref_clk_i = ~ref_clk_i;
   exec_datapath uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .current_instruction_word_i(current_instruction_word), .index_reg_i(idx), .program_base_reg_i(pb),
      .data_base_reg_i(db), .stack_marker_reg_i(sm), .stack_limit_reg_i(sl),
      .base_sel_i(bsel), .addr_calc_i(addr_calc), .left_bus_i(lbus), .left_load_i(lload),
      .right_bus_i(rbus), .right_load_i(rload), .func_i(func), .shift_i(shift),
      .special_i(spec), .src_i(src), .flag_capture_enable_i(flag_en),
      .addr_buf_load_i(abuf_ld), .data_buf_load_i(dbuf_ld), .run_events_i(run_ev),
      .halt_events_i(halt_ev), .effective_address_o(ea), .result_bus_o(res),
      .right_read_o(rread), .status_word_o(stat), .address_output_buffer_o(abuf),
      .data_output_buffer_o(dbuf), .run_interrupt_cause_o(runw),
      .halt_interrupt_cause_o(haltw));
   mem_ctl_model mcu (.ref_clk_i(ref_clk_i), .req_i(mem_req), .address_i(abuf),
      .data_i(dbuf), .taken_address_o(m_addr), .taken_data_o(m_data));
   // one compare, counted, mismatch reported at once
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // let n rising edges pass, stop at a falling edge
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   // counts, verdict, end of run
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // pre-add plus each base in one cycle, hold while idle
   task automatic sc_address();
      current_instruction_word = 16'hab85; idx = 16'h1000; pb = 16'h2000; db = 16'h3000; sm = 16'h4000;
      sl = 16'h5000; addr_calc = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         bsel = base_sel_t'(i);
         step(1);
         check(ea, 16'h3085 + 16'(i) * 16'h1000, "address");
      end
      addr_calc = 1'b0; idx = 16'h0000;
      step(1);
      check(ea, 16'h6085, "address hold");
   endtask
   // operand load, add, both output buffers, memory side takes them
   task automatic sc_add();
      lbus = 16'h1234; rbus = 16'h0f0f; lload = 1'b1; rload = 1'b1;
      step(1);
      lload = 1'b0; rload = 1'b0; func = FN_ADD; abuf_ld = 1'b1; dbuf_ld = 1'b1;
      step(1);
      abuf_ld = 1'b0; dbuf_ld = 1'b0; mem_req = 1'b1; func = FN_XOR;
      check(res, 16'h2143, "add result");
      check(abuf, 16'h2143, "address buffer");
      check(dbuf, 16'h2143, "data buffer");
      step(1);
      mem_req = 1'b0;
      check(res, 16'h1d3b, "xor result");
      check(m_addr, 16'h2143, "memory address");
      check(m_data, 16'h2143, "memory data");
      check(abuf, 16'h2143, "buffer holds");
      func = FN_SUB;
      step(1);
      check(res, 16'h0325, "sub result");
      func = FN_AND;
      step(1);
      check(res, 16'h0204, "and result");
      func = FN_OR;
      step(1);
      check(res, 16'h1f3f, "or result");
      func = FN_INC;
      step(1);
      check(res, 16'h1235, "inc result");
   endtask
   // every shifter code on a passed right operand, then buffer shifts
   task automatic sc_shift();
      lbus = 16'h8c31; rbus = 16'h8c31; lload = 1'b1; rload = 1'b1; func = FN_PASS_R;
      step(1);
      lload = 1'b0; rload = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         shift = shift_t'(i);
         step(1);
         check(res, sh_exp[i], "shifter");
      end
      shift = SH_NONE; func = FN_LSHIFT;
      step(1);
      func = FN_RSHIFT;
      step(1);
      func = FN_NOP;
      step(1);
      check(res, 16'h1862, "left buffer shift");
      func = FN_PASS_R;
      step(1);
      check(res, 16'h4618, "right buffer shift");
   endtask
   // decimal carries, invalid digit, overflow codes
   task automatic sc_decimal();
      lbus = 16'h1999; rbus = 16'h0001; lload = 1'b1; rload = 1'b1; func = FN_DEC_ADD;
      step(1);
      lbus = 16'h00a0; lload = 1'b1; rload = 1'b0;
      step(1);
      lload = 1'b0; flag_en = 1'b1;
      check(res, 16'h2000, "decimal sum");
      step(1);
      flag_en = 1'b0; spec = SP_CLR_OVF;
      check(stat, 16'h0010, "invalid digit");
      step(1);
      spec = SP_SET_OVF;
      check(stat, 16'h0000, "overflow clear");
      step(1);
      spec = SP_NONE;
      check(stat, 16'h0010, "overflow set");
   endtask
   // sticky, constant and live cause bits, reads and clear
   task automatic sc_cause();
      run_ev = 16'h0401; halt_ev = 16'hffff;
      step(3);
      run_ev = 16'h0000; halt_ev = 16'h0000; src = SRC_RUN;
      check(runw, 16'h0001, "run cause");
      check(haltw, 16'he7ff, "halt cause");
      step(1);
      src = SRC_HALT;
      check(rread, 16'h0001, "run read");
      step(1);
      src = SRC_NONE;
      check(rread, 16'he7ff, "halt read");
      step(2);
      spec = SP_CLR_INT;
      check(runw, 16'h0001, "run sticky");
      check(haltw, 16'h07ff, "halt levels follow");
      step(1);
      spec = SP_NONE;
      check(runw, 16'h0000, "run cleared");
      check(haltw, 16'h0000, "halt cleared");
      check(rread, 16'h0000, "no source");
   endtask
   // main sequence
   initial
   begin
      {addr_calc, lload, rload, flag_en, abuf_ld, dbuf_ld, mem_req} = '0;
      {current_instruction_word, idx, pb, db, sm, sl, lbus, rbus, run_ev, halt_ev} = '0;
      bsel = BASE_PROGRAM; func = FN_NOP; shift = SH_NONE; spec = SP_NONE; src = SRC_NONE;
      step(16);
      reset_i = 1'b0;
      check(stat | abuf | dbuf | runw | haltw, 16'h0000, "reset values");
      sc_address();
      sc_add();
      sc_shift();
      sc_decimal();
      sc_cause();
      close_out();
   end
endmodule
`default_nettype wire
